// ==== include/pcib_pkg.sv ====
// constants and types shared by the 64-bit burst write data path
package pcib_pkg;
	localparam int unsigned DATA_W   = 64;
	localparam int unsigned BE_W     = 8;
	localparam int unsigned CNT_W    = 16;
	localparam int unsigned STAT_W   = 4;
	localparam int unsigned TERM_W   = 2;
	localparam int unsigned HALF_W   = 32;

	// master phase state codes seen by the local side
	localparam logic [STAT_W-1:0] ST_IDLE      = 4'h0;
	localparam logic [STAT_W-1:0] ST_BUS_TRANS = 4'h2;
	localparam logic [STAT_W-1:0] ST_BUS_TERM  = 4'h3;

	localparam logic [TERM_W-1:0] TERM_NONE    = 2'h0;
	localparam logic [TERM_W-1:0] TERM_NORMAL  = 2'h1;

	// register map, byte addresses
	localparam logic [7:0] REG_CTRL_OFS = 8'h00;
	localparam logic [7:0] REG_STAT_OFS = 8'h04;
	localparam logic [7:0] REG_CNT_OFS  = 8'h08;
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned STAT_TERM_LSB  = 4;
	localparam int unsigned STAT_WIDE_BIT  = 8;
	localparam logic        CTRL_EN_RST    = 1'b0;

	// reset values
	localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 64'h0000000000000000;
	localparam logic [BE_W-1:0]   BE_RST   = 8'hFF;
	localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD    = 3'b010;

	typedef enum logic [2:0] {
		PH_IDLE   = 3'b000,
		PH_ADDR   = 3'b001,
		PH_DECODE = 3'b010,
		PH_WIDTH  = 3'b011,
		PH_DATA   = 3'b100,
		PH_TURN   = 3'b101
	} pcib_phase_t;
endpackage

// ==== src/pcib_parity.sv ====
// even parity over the low and high lanes, one clock behind the bus
`timescale 1ns/10ps
module pcib_parity (
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	input  wire logic [pcib_pkg::DATA_W-1:0]  ad,
	input  wire logic [pcib_pkg::BE_W-1:0]    cbe,
	input  wire logic                         ad_oe,
	output logic                              par,
	output logic                              par64,
	output logic                              par_oe
);
	import pcib_pkg::*;

	logic [1:0] lane_par;
	logic [1:0] next_lane_par;
	logic       next_par_oe;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_lane
			always_comb begin
				next_lane_par[g] = ^{ad[g*HALF_W +: HALF_W], cbe[g*4 +: 4]};
			end
		end
	endgenerate

	always_comb begin
		next_par_oe = ad_oe;
	end

	// parity lags its data by a clock, so it stays driven one idle clock
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lane_par <= 2'b00;
			par_oe   <= 1'b0;
		end else begin
			lane_par <= next_lane_par;
			par_oe   <= next_par_oe;
		end
	end

	always_comb begin
		par   = lane_par[0];
		par64 = lane_par[1];
	end
endmodule

// ==== src/pcib_ahb_regs.sv ====
// AHB-Lite register slave: enable control and burst status readback
`timescale 1ns/10ps
module pcib_ahb_regs (
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata,
	output logic                              burst_enable,
	input  wire logic [pcib_pkg::STAT_W-1:0]  phase_state,
	input  wire logic [pcib_pkg::TERM_W-1:0]  term_cause,
	input  wire logic                         wide_n,
	input  wire logic [pcib_pkg::CNT_W-1:0]   burst_count
);
	import pcib_pkg::*;

	logic        wr_pend;
	logic [7:0]  wr_addr;
	logic        next_wr_pend;
	logic [7:0]  next_wr_addr;
	logic        next_enable;
	logic [31:0] next_hrdata;
	logic        take;

	function automatic logic [31:0] read_mux(input logic [7:0] a,
		input logic en, input logic [STAT_W-1:0] st,
		input logic [TERM_W-1:0] tc, input logic wn,
		input logic [CNT_W-1:0] cnt);
		logic [31:0] v;
		v = 32'h00000000;
		case (a)
			REG_CTRL_OFS: v[CTRL_EN_BIT] = en;
			REG_STAT_OFS: begin
				v[STAT_W-1:0] = st;
				v[STAT_TERM_LSB +: TERM_W] = tc;
				v[STAT_WIDE_BIT] = ~wn;
			end
			REG_CNT_OFS:  v[CNT_W-1:0] = cnt;
			default:      v = 32'h00000000;
		endcase
		return v;
	endfunction

	always_comb begin
		take         = hsel && hready && (htrans == HTRANS_NONSEQ)
			&& (hsize == HSIZE_WORD);
		next_wr_pend = take && hwrite;
		next_wr_addr = take ? haddr[7:0] : wr_addr;
		next_enable  = burst_enable;
		if (wr_pend && (wr_addr == REG_CTRL_OFS)) begin
			next_enable = hwdata[CTRL_EN_BIT];
		end
		// read data registered in the address phase: zero wait states
		next_hrdata = 32'h00000000;
		if (take && !hwrite) begin
			next_hrdata = read_mux(haddr[7:0], burst_enable, phase_state,
				term_cause, wide_n, burst_count);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_pend      <= 1'b0;
			wr_addr      <= 8'h00;
			burst_enable <= CTRL_EN_RST;
			hrdata       <= 32'h00000000;
			hreadyout    <= 1'b0;
			hresp        <= 1'b0;
		end else begin
			wr_pend      <= next_wr_pend;
			wr_addr      <= next_wr_addr;
			burst_enable <= next_enable;
			hrdata       <= next_hrdata;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
		end
	end
endmodule

// ==== src/pcib_write_burst.sv ====
// 64-bit PCI master burst write: data phases and normal termination
`timescale 1ns/10ps
// Summary of operation
// - on ready, first strobe already in address phase; after claim and ready, assert irdy
// - irdy and trdy low completes a phase
// - count down one after each completion
// - ready previous clock gives strobes; trdy also needed once in data phase
// - accepted QWORD replaced by captured next one
// - irdy held while local ready was asserted
// - frame held; last phase drops frame, req64, strobes
// - turnaround releases bus, count zero, normal end
// - idle clock stops driving irdy and parity
// - wide flag asserted before first phase completes
// - address phase loads count with burst length
module pcib_write_burst (
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata,
	input  wire logic                         start_burst,
	input  wire logic [31:0]                  start_address,
	input  wire logic [3:0]                   bus_command,
	input  wire logic [pcib_pkg::CNT_W-1:0]   burst_length,
	input  wire logic [pcib_pkg::DATA_W-1:0]  local_data_in,
	input  wire logic [pcib_pkg::BE_W-1:0]    local_byte_enables_in,
	input  wire logic                         local_side_ready_n,
	output logic                              low_half_xfer_strobe_n,
	output logic                              high_half_xfer_strobe_n,
	output logic                              wide_transfer_flag_n,
	output logic [pcib_pkg::CNT_W-1:0]        remaining_burst_count,
	output logic [pcib_pkg::STAT_W-1:0]       master_phase_state,
	output logic [pcib_pkg::TERM_W-1:0]       termination_cause,
	output logic                              frame_n_o,
	output logic                              frame_oe,
	output logic                              req64_n_o,
	output logic                              req64_oe,
	output logic                              irdy_n_o,
	output logic                              irdy_oe,
	output logic [pcib_pkg::DATA_W-1:0]       ad_o,
	output logic                              ad_oe,
	output logic [pcib_pkg::BE_W-1:0]         cbe_n_o,
	output logic                              cbe_oe,
	output logic                              par_o,
	output logic                              par64_o,
	output logic                              par_oe,
	input  wire logic                         devsel_n_i,
	input  wire logic                         trdy_n_i,
	input  wire logic                         ack64_n_i
);
	import pcib_pkg::*;

	pcib_phase_t       phase;
	pcib_phase_t       next_phase;
	logic              strobe_n;
	logic              next_strobe_n;
	logic              ad_valid;
	logic              next_ad_valid;
	logic              staged_valid;
	logic              next_staged_valid;
	logic [DATA_W-1:0] staged_data;
	logic [DATA_W-1:0] next_staged_data;
	logic [BE_W-1:0]   staged_be;
	logic [BE_W-1:0]   next_staged_be;
	logic [CNT_W-1:0]  fetch_left;
	logic [CNT_W-1:0]  next_fetch_left;
	logic [CNT_W-1:0]  next_count;
	logic [STAT_W-1:0] next_state_code;
	logic [TERM_W-1:0] next_term;
	logic              next_wide_n;
	logic              next_frame_n;
	logic              next_frame_oe;
	logic              next_req64_n;
	logic              next_req64_oe;
	logic              next_irdy_n;
	logic              next_irdy_oe;
	logic [DATA_W-1:0] next_ad;
	logic              next_ad_oe;
	logic [BE_W-1:0]   next_cbe_n;
	logic              next_cbe_oe;
	logic              burst_enable;
	logic              done;
	logic              capture;
	logic              slot_free;
	logic              may_fetch;

	pcib_ahb_regs u_regs (
		.core_clk     (core_clk),
		.sys_rst      (sys_rst),
		.hsel         (hsel),
		.haddr        (haddr),
		.htrans       (htrans),
		.hwrite       (hwrite),
		.hsize        (hsize),
		.hwdata       (hwdata),
		.hready       (hready),
		.hreadyout    (hreadyout),
		.hresp        (hresp),
		.hrdata       (hrdata),
		.burst_enable (burst_enable),
		.phase_state  (master_phase_state),
		.term_cause   (termination_cause),
		.wide_n       (wide_transfer_flag_n),
		.burst_count  (remaining_burst_count)
	);

	pcib_parity u_parity (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.ad       (ad_o),
		.cbe      (cbe_n_o),
		.ad_oe    (ad_oe),
		.par      (par_o),
		.par64    (par64_o),
		.par_oe   (par_oe)
	);

	always_comb begin
		next_phase        = phase;
		next_strobe_n     = 1'b1;
		next_ad_valid     = ad_valid;
		next_staged_valid = staged_valid;
		next_staged_data  = staged_data;
		next_staged_be    = staged_be;
		next_fetch_left   = fetch_left;
		next_count        = remaining_burst_count;
		next_state_code   = master_phase_state;
		next_term         = termination_cause;
		next_wide_n       = wide_transfer_flag_n;
		next_frame_n      = frame_n_o;
		next_frame_oe     = frame_oe;
		next_req64_n      = req64_n_o;
		next_req64_oe     = req64_oe;
		next_irdy_n       = irdy_n_o;
		next_irdy_oe      = irdy_oe;
		next_ad           = ad_o;
		next_ad_oe        = ad_oe;
		next_cbe_n        = cbe_n_o;
		next_cbe_oe       = cbe_oe;

		done = (phase == PH_DATA) && !irdy_n_o && !trdy_n_i;
		// a strobe cycle is the one in which the local QWORD is taken
		capture   = !strobe_n;
		slot_free = !ad_valid || done;
		may_fetch = (fetch_left != CNT_RST);

		if (done) begin
			next_count = remaining_burst_count - CNT_ONE;
		end

		// the local side holds its QWORD until a strobe takes it
		if (capture) begin
			next_fetch_left = fetch_left - CNT_ONE;
			if (slot_free) begin
				next_ad       = local_data_in;
				next_cbe_n    = local_byte_enables_in;
				next_ad_valid = 1'b1;
			end else begin
				// target stalled: park the QWORD until the slot frees
				next_staged_data  = local_data_in;
				next_staged_be    = local_byte_enables_in;
				next_staged_valid = 1'b1;
			end
		end else if (done) begin
			if (staged_valid) begin
				next_ad           = staged_data;
				next_cbe_n        = staged_be;
				next_staged_valid = 1'b0;
			end else begin
				next_ad_valid = 1'b0;
			end
		end

		case (phase)
			PH_IDLE: begin
				next_irdy_oe = 1'b0;
				if (start_burst && burst_enable) begin
					next_phase        = PH_ADDR;
					next_count        = burst_length;
					next_fetch_left   = burst_length;
					next_state_code   = ST_BUS_TRANS;
					next_term         = TERM_NONE;
					next_wide_n       = 1'b1;
					next_frame_n      = 1'b0;
					next_frame_oe     = 1'b1;
					next_req64_n      = 1'b0;
					next_req64_oe     = 1'b1;
					next_irdy_n       = 1'b1;
					next_irdy_oe      = 1'b1;
					next_ad           = {32'h00000000, start_address};
					next_ad_oe        = 1'b1;
					next_cbe_n        = {4'hF, bus_command};
					next_cbe_oe       = 1'b1;
					next_ad_valid     = 1'b0;
					next_staged_valid = 1'b0;
					next_strobe_n     = !(!local_side_ready_n &&
						(burst_length != CNT_RST));
				end
			end
			PH_ADDR: begin
				next_phase = PH_DECODE;
			end
			PH_DECODE: begin
				// width is judged in the same clock as the claim
				if (!devsel_n_i) begin
					next_phase  = PH_WIDTH;
					next_wide_n = ack64_n_i;
				end
			end
			PH_WIDTH: begin
				next_phase    = PH_DATA;
				next_strobe_n = !(!local_side_ready_n && may_fetch &&
					!next_staged_valid);
				next_irdy_n   = !(next_ad_valid && (!local_side_ready_n
					|| next_fetch_left == CNT_RST));
				next_frame_n  = (remaining_burst_count == CNT_ONE);
				next_req64_n  = (remaining_burst_count == CNT_ONE);
			end
			PH_DATA: begin
				if (done && (remaining_burst_count == CNT_ONE)) begin
					next_phase      = PH_TURN;
					next_frame_oe   = 1'b0;
					next_req64_oe   = 1'b0;
					next_ad_oe      = 1'b0;
					next_cbe_oe     = 1'b0;
					next_irdy_n     = 1'b1;
					next_state_code = ST_BUS_TERM;
					next_term       = TERM_NORMAL;
				end else begin
					next_strobe_n = !(!local_side_ready_n && !trdy_n_i &&
						may_fetch && !next_staged_valid);
					next_irdy_n   = !(next_ad_valid && (!local_side_ready_n
						|| next_fetch_left == CNT_RST));
					if (next_count == CNT_ONE) begin
						next_frame_n = 1'b1;
						next_req64_n = 1'b1;
					end
				end
			end
			PH_TURN: begin
				next_phase   = PH_IDLE;
				next_irdy_oe = 1'b0;
			end
			default: begin
				next_phase    = PH_IDLE;
				next_frame_oe = 1'b0;
				next_req64_oe = 1'b0;
				next_irdy_oe  = 1'b0;
				next_ad_oe    = 1'b0;
				next_cbe_oe   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase                   <= PH_IDLE;
			strobe_n                <= 1'b1;
			ad_valid                <= 1'b0;
			staged_valid            <= 1'b0;
			staged_data             <= DATA_RST;
			staged_be               <= BE_RST;
			fetch_left              <= CNT_RST;
			remaining_burst_count   <= CNT_RST;
			master_phase_state      <= ST_IDLE;
			termination_cause       <= TERM_NONE;
			wide_transfer_flag_n    <= 1'b1;
			frame_n_o               <= 1'b1;
			frame_oe                <= 1'b0;
			req64_n_o               <= 1'b1;
			req64_oe                <= 1'b0;
			irdy_n_o                <= 1'b1;
			irdy_oe                 <= 1'b0;
			ad_o                    <= DATA_RST;
			ad_oe                   <= 1'b0;
			cbe_n_o                 <= BE_RST;
			cbe_oe                  <= 1'b0;
			low_half_xfer_strobe_n  <= 1'b1;
			high_half_xfer_strobe_n <= 1'b1;
		end else begin
			phase                   <= next_phase;
			strobe_n                <= next_strobe_n;
			ad_valid                <= next_ad_valid;
			staged_valid            <= next_staged_valid;
			staged_data             <= next_staged_data;
			staged_be               <= next_staged_be;
			fetch_left              <= next_fetch_left;
			remaining_burst_count   <= next_count;
			master_phase_state      <= next_state_code;
			termination_cause       <= next_term;
			wide_transfer_flag_n    <= next_wide_n;
			frame_n_o               <= next_frame_n;
			frame_oe                <= next_frame_oe;
			req64_n_o               <= next_req64_n;
			req64_oe                <= next_req64_oe;
			irdy_n_o                <= next_irdy_n;
			irdy_oe                 <= next_irdy_oe;
			ad_o                    <= next_ad;
			ad_oe                   <= next_ad_oe;
			cbe_n_o                 <= next_cbe_n;
			cbe_oe                  <= next_cbe_oe;
			// both halves move together on a 64-bit local path
			low_half_xfer_strobe_n  <= next_strobe_n;
			high_half_xfer_strobe_n <= next_strobe_n;
		end
	end
endmodule

// ==== dv/pcib_wb_props.sv ====
// concurrent checks on the burst write data phases and termination
`timescale 1ns/10ps
module pcib_wb_props
	import pcib_pkg::*;
(
	input wire logic                        core_clk,
	input wire logic                        sys_rst,
	input wire logic [31:0]                 start_address,
	input wire logic [3:0]                  bus_command,
	input wire logic [pcib_pkg::CNT_W-1:0]  burst_length,
	input wire logic                        local_side_ready_n,
	input wire logic                        low_half_xfer_strobe_n,
	input wire logic                        high_half_xfer_strobe_n,
	input wire logic                        wide_transfer_flag_n,
	input wire logic [pcib_pkg::CNT_W-1:0]  remaining_burst_count,
	input wire logic [pcib_pkg::STAT_W-1:0] master_phase_state,
	input wire logic [pcib_pkg::TERM_W-1:0] termination_cause,
	input wire logic                        frame_n_o,
	input wire logic                        frame_oe,
	input wire logic                        req64_n_o,
	input wire logic                        req64_oe,
	input wire logic                        irdy_n_o,
	input wire logic                        irdy_oe,
	input wire logic [pcib_pkg::DATA_W-1:0] ad_o,
	input wire logic                        ad_oe,
	input wire logic [pcib_pkg::BE_W-1:0]   cbe_n_o,
	input wire logic                        cbe_oe,
	input wire logic                        par_oe,
	input wire logic                        trdy_n_i,
	input wire logic                        ack64_n_i
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence last_phase_s;
		frame_oe && !irdy_n_o && !trdy_n_i && remaining_burst_count == CNT_ONE;
	endsequence
	sequence turn_s;
		!frame_oe && !req64_oe && !ad_oe && !cbe_oe && irdy_oe && irdy_n_o
		&& remaining_burst_count == CNT_RST && master_phase_state == ST_BUS_TERM
		&& termination_cause == TERM_NORMAL;
	endsequence
	sequence idle_s;
		!irdy_oe && !par_oe;
	endsequence

	turn_release_a: assert property (
		last_phase_s |=> turn_s) else $error("turnaround not clean");
	idle_release_a: assert property (
		last_phase_s ##1 turn_s |=> idle_s) else $error("irdy or par kept");
	phase_done_a: assert property (
		irdy_oe && !irdy_n_o && !trdy_n_i |=> remaining_burst_count ==
		$past(remaining_burst_count) - CNT_ONE) else $error("count not down");
	strobe_cause_a: assert property (
		!low_half_xfer_strobe_n |-> !$past(local_side_ready_n)
		&& !high_half_xfer_strobe_n) else $error("strobe without ready");
	ready_irdy_a: assert property (
		!irdy_n_o && !local_side_ready_n && !(!trdy_n_i
		&& remaining_burst_count == CNT_ONE) |=> !irdy_n_o)
		else $error("irdy dropped");
	ad_next_a: assert property (
		!irdy_n_o && !trdy_n_i && remaining_burst_count > CNT_ONE
		|=> ad_o != $past(ad_o) || irdy_n_o) else $error("ad not advanced");
	frame_hold_a: assert property (
		frame_oe && master_phase_state == ST_BUS_TRANS
		&& remaining_burst_count > CNT_ONE |-> !frame_n_o)
		else $error("frame released early");
	last_frame_a: assert property (
		frame_oe && !irdy_n_o && remaining_burst_count == CNT_ONE
		|-> frame_n_o && req64_n_o && low_half_xfer_strobe_n
		&& high_half_xfer_strobe_n) else $error("last phase wrong");
	wide_flag_a: assert property (
		!irdy_n_o && !trdy_n_i && !ack64_n_i |-> !wide_transfer_flag_n)
		else $error("wide flag not set");
	load_count_a: assert property (
		$rose(frame_oe) |-> !frame_n_o && !req64_n_o
		&& remaining_burst_count == $past(burst_length)
		&& ad_o[31:0] == $past(start_address)
		&& cbe_n_o[3:0] == $past(bus_command)) else $error("bad address phase");
	frame_pair_a: assert property (
		frame_oe |-> frame_n_o == req64_n_o) else $error("frame req64 split");
endmodule

bind pcib_write_burst pcib_wb_props u_props (
	.core_clk(core_clk), .sys_rst(sys_rst), .start_address(start_address),
	.bus_command(bus_command), .burst_length(burst_length),
	.local_side_ready_n(local_side_ready_n),
	.low_half_xfer_strobe_n(low_half_xfer_strobe_n),
	.high_half_xfer_strobe_n(high_half_xfer_strobe_n),
	.wide_transfer_flag_n(wide_transfer_flag_n),
	.remaining_burst_count(remaining_burst_count),
	.master_phase_state(master_phase_state),
	.termination_cause(termination_cause), .frame_n_o(frame_n_o),
	.frame_oe(frame_oe), .req64_n_o(req64_n_o), .req64_oe(req64_oe),
	.irdy_n_o(irdy_n_o), .irdy_oe(irdy_oe), .ad_o(ad_o), .ad_oe(ad_oe),
	.cbe_n_o(cbe_n_o), .cbe_oe(cbe_oe), .par_oe(par_oe),
	.trdy_n_i(trdy_n_i), .ack64_n_i(ack64_n_i));

// ==== dv/pcib_partner.sv ====
// local master back-end and 64-bit pci target model
`timescale 1ns/10ps
module pcib_partner
	import pcib_pkg::*;
(
	input  wire logic                        core_clk,
	input  wire logic                        sys_rst,
	input  wire logic [pcib_pkg::CNT_W-1:0]  burst_length,
	input  wire logic                        stall,
	input  wire logic                        low_half_xfer_strobe_n,
	input  wire logic                        frame_n_o,
	input  wire logic                        frame_oe,
	input  wire logic                        irdy_n_o,
	input  wire logic                        irdy_oe,
	output logic [pcib_pkg::DATA_W-1:0]      local_data_in,
	output logic [pcib_pkg::BE_W-1:0]        local_byte_enables_in,
	output logic                             local_side_ready_n,
	output logic                             devsel_n_i,
	output logic                             trdy_n_i,
	output logic                             ack64_n_i
);
	logic [15:0] idx;
	logic [15:0] next_idx;
	logic        claimed;
	logic        next_claimed;

	always_comb begin
		next_idx = idx;
		next_claimed = claimed;
		if (!frame_oe && !irdy_oe)
			next_idx = 16'h0000;
		else if (!low_half_xfer_strobe_n)
			next_idx = idx + 16'h0001;
		if (frame_oe && !frame_n_o)
			next_claimed = 1'b1;
		else if (frame_n_o && !irdy_n_o && !trdy_n_i)
			next_claimed = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			idx <= 16'h0000;
			claimed <= 1'b0;
		end else begin
			idx <= next_idx;
			claimed <= next_claimed;
		end
	end

	// data only moves on a taken pair; past the end it is scrambled
	assign local_data_in = (idx < burst_length) ?
		{48'hA5A500000000, idx + 16'h0001} : ~{48'hA5A500000000, idx};
	assign local_byte_enables_in = 8'h11 + idx[7:0];
	assign local_side_ready_n = (idx >= burst_length) ||
		(idx + 16'h0001 == burst_length && !low_half_xfer_strobe_n);
	// released target lines float to the pull-up level
	assign devsel_n_i = ~claimed;
	assign ack64_n_i = ~claimed;
	assign trdy_n_i = ~(claimed & ~stall);
endmodule

// ==== dv/pcib_write_burst_tb_top.sv ====
// self-checking bench for the 64-bit burst write bridge
`timescale 1ns/10ps
module pcib_write_burst_tb_top;
	import pcib_pkg::*;
	logic        core_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, start_address, scratch;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        start_burst, stall, ready_n, lo_n, hi_n, wide_n;
	logic [3:0]  bus_command;
	logic [CNT_W-1:0]  burst_length, cnt;
	logic [DATA_W-1:0] ldata, ad_o;
	logic [BE_W-1:0]   lbe, cbe_n_o;
	logic [STAT_W-1:0] state;
	logic [TERM_W-1:0] term;
	logic frame_n_o, frame_oe, req64_n_o, req64_oe, irdy_n_o, irdy_oe, ad_oe;
	logic cbe_oe, par_o, par64_o, par_oe, devsel_n, trdy_n, ack64_n;
	int n_fail, n_checks;

	assign hready = hreadyout;
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	pcib_write_burst u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.start_burst(start_burst), .start_address(start_address),
		.bus_command(bus_command), .burst_length(burst_length),
		.local_data_in(ldata), .local_byte_enables_in(lbe),
		.local_side_ready_n(ready_n), .low_half_xfer_strobe_n(lo_n),
		.high_half_xfer_strobe_n(hi_n), .wide_transfer_flag_n(wide_n),
		.remaining_burst_count(cnt), .master_phase_state(state),
		.termination_cause(term), .frame_n_o(frame_n_o), .frame_oe(frame_oe),
		.req64_n_o(req64_n_o), .req64_oe(req64_oe), .irdy_n_o(irdy_n_o),
		.irdy_oe(irdy_oe), .ad_o(ad_o), .ad_oe(ad_oe), .cbe_n_o(cbe_n_o),
		.cbe_oe(cbe_oe), .par_o(par_o), .par64_o(par64_o), .par_oe(par_oe),
		.devsel_n_i(devsel_n), .trdy_n_i(trdy_n), .ack64_n_i(ack64_n));

	pcib_partner u_partner (.core_clk(core_clk), .sys_rst(sys_rst),
		.burst_length(burst_length), .stall(stall),
		.low_half_xfer_strobe_n(lo_n), .frame_n_o(frame_n_o),
		.frame_oe(frame_oe), .irdy_n_o(irdy_n_o), .irdy_oe(irdy_oe),
		.local_data_in(ldata), .local_byte_enables_in(lbe),
		.local_side_ready_n(ready_n), .devsel_n_i(devsel_n),
		.trdy_n_i(trdy_n), .ack64_n_i(ack64_n));

	task test_done;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one single-word transfer; entered just after a rising edge
	task ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		@(posedge core_clk);
		while (hready !== 1'b1)
			@(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge core_clk);
		while (hready !== 1'b1)
			@(posedge core_clk);
		rd = hrdata;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		ahb({24'h0, a}, 1'b0, 32'h0, scratch);
		chk(nm, {31'h0, exp, 1'b0}, {31'h0, scratch, hresp});
	endtask

	task burst(input logic [15:0] len, input logic [3:0] smask);
		int k;
		int c;
		k = 0;
		burst_length <= len;
		start_address <= 32'h00004000 + {16'h0, len};
		bus_command <= 4'h7;
		start_burst <= 1'b1;
		@(posedge core_clk);
		start_burst <= 1'b0;
		for (c = 0; c < 300; c++) begin
			@(negedge core_clk);
			if (state === ST_BUS_TERM)
				break;
			if (irdy_oe === 1'b1 && irdy_n_o === 1'b0 && trdy_n === 1'b0) begin
				k++;
				chk("ad", {48'hA5A500000000, k[15:0]}, ad_o);
				chk("cbe", {56'h0, 8'h10 + k[7:0]}, {56'h0, cbe_n_o});
				chk("count", {48'h0, len - k[15:0] + 16'h1}, {48'h0, cnt});
			end
			@(posedge core_clk);
			stall <= smask[c % 4];
		end
		chk("phases", {48'h0, len}, {48'h0, k[15:0]});
		chk("end count", 64'h0, {48'h0, cnt});
		chk("end cause", {62'h0, TERM_NORMAL}, {62'h0, term});
		chk("bus freed", 64'h0, {61'h0, frame_oe, ad_oe, cbe_oe});
		@(negedge core_clk);
		chk("irdy freed", 64'h0, {62'h0, irdy_oe, par_oe});
		@(posedge core_clk);
		stall <= 1'b0;
	endtask

	initial begin
		#(20 * 20000);
		n_fail++;
		test_done;
	end

	initial begin
		sys_rst = 1'b1;
		{hsel, hwrite, start_burst, stall} = 4'h0;
		{haddr, hwdata, start_address} = 96'h0;
		htrans = 2'b00;
		hsize = 3'h0;
		bus_command = 4'h0;
		burst_length = 16'h0000;
		n_fail = 0;
		n_checks = 0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		chk("reset oe", 64'h0, {58'h0, frame_oe, req64_oe, irdy_oe, ad_oe,
			cbe_oe, par_oe});
		chk("reset low", 64'h7, {61'h0, lo_n, hi_n, wide_n});
		chk("reset cbe", {56'h0, BE_RST}, {56'h0, cbe_n_o});
		chk("reset cnt", 64'h0, {44'h0, cnt, state}); 
		@(posedge core_clk);
		rd_chk(REG_CTRL_OFS, 32'h0, "ctrl reset");
		// a start while disabled must not reach the bus
		burst_length <= 16'h0002;
		start_burst <= 1'b1;
		repeat (4) @(posedge core_clk);
		start_burst <= 1'b0;
		@(negedge core_clk);
		chk("disabled", 64'h0, {63'h0, frame_oe});
		@(posedge core_clk);
		ahb({24'h0, REG_CTRL_OFS}, 1'b1, 32'h1, scratch);
		rd_chk(REG_CTRL_OFS, 32'h1, "ctrl");
		ahb({24'h0, REG_STAT_OFS}, 1'b1, 32'hFFFF, scratch);
		rd_chk(REG_STAT_OFS, 32'h0, "status ro");
		rd_chk(8'h40, 32'h0, "unmapped");
		burst(16'h0003, 4'b0000);
		burst(16'h0004, 4'b0010);
		burst(16'h0001, 4'b0000);
		burst(16'h0002, 4'b0101);
		rd_chk(REG_CNT_OFS, 32'h0, "count reg");
		test_done;
	end
endmodule
